/* hw/link_map.svh */
// register map, field positions, reset values and timing counts of the parallel link
`ifndef LINK_MAP_SVH
`define LINK_MAP_SVH

// register word indices; byte address is four times the index
`define CMD_IDX 10'h0c4
`define CFG_IDX 10'h0c6
`define STAT_IDX 10'h0c8

// link_configuration fields
`define CFG_PULSE_BIT 12
`define CFG_KEEP_BIT 11
`define CFG_HSWAP_BIT 10
`define CFG_INVERT_BIT 9
`define CFG_BSWAP_BIT 8
`define CFG_RTIME_BIT 7
`define CFG_IN_LSB 5
`define CFG_OUT_LSB 3
`define CFG_ENB_BIT 2
`define CFG_REQPOL_BIT 1
`define CFG_SPOL_BIT 0
`define CFG_MASK 16'h1fff
`define CFG_RESET 16'h0000

// command fields
`define CMD_FN3_BIT 6
`define CMD_FN2_BIT 5
`define CMD_FN1_BIT 4
`define CMD_DIR_BIT 3
`define CMD_MASK 16'h0078
`define CMD_RESET 16'h0000

// status fields
`define STAT_READY_BIT 0
`define STAT_STROBE_BIT 1
`define STAT_ATT_BIT 2
`define STAT_BLOCK_BIT 3
`define STAT_JUMPER_BIT 4
`define STAT_FN2_BIT 5

// pin synchroniser reset: jumper assumed installed
`define SYNC_RESET 20'h80000

// timing in ns and derived cycle counts
`define CLK_NS 5
`define STEP_NS 40
`define STEP_CYC ((`STEP_NS + `CLK_NS - 1) / `CLK_NS)
`define SETUP_MIN_NS 10
`define SETUP_MIN_CYC ((`SETUP_MIN_NS + `CLK_NS - 1) / `CLK_NS)
`define FN_PULSE_NS 300
`define FN_PULSE_CYC (`FN_PULSE_NS / `CLK_NS)

`endif

/* hw/link_pkg.sv */
// types shared by the parallel link configuration and timing logic
package link_pkg;
    typedef enum {seq_idle, seq_strobe} seq_state_type;
    typedef enum {sel_none, sel_cmd, sel_cfg, sel_stat} reg_sel_type;
endpackage

/* hw/strobe_sequencer.sv */
// strobe, sample and ready timing for one word on the parallel link
`timescale 1ns/10ps
`include "link_map.svh"
module strobe_sequencer (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // transfer control
    input wire logic start,
    input wire logic last,
    input wire logic ready_late,
    input wire logic [1:0] in_code,
    input wire logic [1:0] out_code,
    // timing outputs
    output logic strobe,
    output logic sample,
    output logic ready,
    output logic eoc,
    output logic done
);

    // cycles from strobe start to data sampling
    function automatic logic [7:0] in_cycles(input logic [1:0] code);
        in_cycles = 8'((32'(code) + 1) * `STEP_CYC);
    endfunction

    // cycles of data setup before the strobe ends
    function automatic logic [7:0] out_cycles(input logic [1:0] code);
        out_cycles = 8'(`SETUP_MIN_CYC + 32'(code) * `STEP_CYC);
    endfunction

    link_pkg::seq_state_type state_r, state_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic [7:0] in_len;
    logic [7:0] len;
    logic ready_r, ready_nxt;
    logic eoc_r, eoc_nxt;
    logic last_r, last_nxt;

    // strobe lasts until both the sample point and the setup time are past
    always_comb begin
        in_len = in_cycles(in_code);
        len = out_cycles(out_code);
        if (in_len + 8'h01 > len) begin
            len = in_len + 8'h01;
        end
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        ready_nxt = ready_r;
        eoc_nxt = 1'b0;
        last_nxt = last_r;
        sample = 1'b0;
        done = 1'b0;
        case (state_r)
            link_pkg::seq_idle: begin
                if (start) begin
                    state_nxt = link_pkg::seq_strobe;
                    cnt_nxt = 8'h00;
                    ready_nxt = 1'b0;
                    last_nxt = last;
                end
            end
            link_pkg::seq_strobe: begin
                cnt_nxt = cnt_r + 8'h01;
                sample = (cnt_r == in_len - 8'h01);
                // early ready: strobe of the last word is still active
                if (sample && last_r && !ready_late) begin
                    ready_nxt = 1'b1;
                end
                if (cnt_r == len - 8'h01) begin
                    state_nxt = link_pkg::seq_idle;
                    done = 1'b1;
                    ready_nxt = 1'b1;
                    eoc_nxt = last_r;
                end
            end
            default: begin
                state_nxt = link_pkg::seq_idle;
            end
        endcase
    end

    // codes are read live, so software must not retime during a strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= link_pkg::seq_idle;
            cnt_r <= 8'h00;
            ready_r <= 1'b1;
            eoc_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            ready_r <= ready_nxt;
            eoc_r <= eoc_nxt;
            last_r <= last_nxt;
        end
    end

    assign strobe = (state_r == link_pkg::seq_strobe);
    assign ready = ready_r;
    assign eoc = eoc_r;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sample_delay_a: assert property (
        $rose(strobe) && in_code == 2'b00 |-> !sample [*7] ##1 sample)
        else $error("input sample not 8 cycles after strobe start");

    setup_long_a: assert property (
        $rose(strobe) && in_code == 2'b00 && out_code == 2'b11
        |-> strobe ##25 strobe ##1 !strobe)
        else $error("strobe length wrong for longest output setup");

    ready_early_a: assert property (
        $rose(ready) && last_r && !ready_late |-> strobe)
        else $error("early ready came after the last strobe");

    ready_late_a: assert property (
        $rose(ready) && last_r && ready_late |-> !strobe && eoc)
        else $error("late ready not at strobe end with end of cycle");

endmodule

/* hw/parallel_link_config_timing.sv */
// configuration, pin conditioning and word timing of the parallel link port
// Notes on behaviour
// - pulse mode: 300 ns pulse per function-two change
// - otherwise function line two follows its bit
// - keep bit stops attention aborting the dma
// - halfword order bit swaps word halves
// - invert bit inverts link data
// - byte order bit swaps bytes in halfword
// - ready timing 0: ready during last strobe
// - ready timing 1: ready at strobe end
// - input sample 40 ns plus 40 ns steps
// - output setup 10 ns plus 40 ns steps
// - enabled request b when active blocks transfers
// - polarity bit picks starting request edge
// - strobe polarity 0 drives strobe active high
// - missing jumper forces strobe active low
// - command function bits drive function lines
//
// Added by the designer: the APB register port.
`timescale 1ns/10ps
`include "link_map.svh"
module parallel_link_config_timing (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // link pins in
    input wire logic cycle_request_a,
    input wire logic cycle_request_b,
    input wire logic attention_input,
    input wire logic strobe_jumper_present,
    input wire logic [15:0] link_data_in,
    // link pins out
    output logic transfer_strobe_output,
    output logic device_ready,
    output logic end_of_cycle,
    output logic function_line_one,
    output logic function_line_two,
    output logic function_line_three,
    output logic [15:0] link_data_out,
    output logic link_data_oe,
    // dma engine side
    input wire logic dma_active,
    input wire logic dma_last,
    input wire logic dma_half_sel,
    input wire logic [31:0] dma_wdata,
    output logic dma_word_done,
    output logic [31:0] dma_rdata,
    output logic dma_rdata_valid,
    output logic dma_abort
);

    // register decode, shared by read and write paths
    function automatic link_pkg::reg_sel_type reg_sel(input logic [11:0] addr);
        case (addr[11:2])
            `CMD_IDX: reg_sel = link_pkg::sel_cmd;
            `CFG_IDX: reg_sel = link_pkg::sel_cfg;
            `STAT_IDX: reg_sel = link_pkg::sel_stat;
            default: reg_sel = link_pkg::sel_none;
        endcase
    endfunction

    // byte order and inversion, same in both directions
    function automatic logic [15:0] order_bits(input logic [15:0] h,
                                               input logic bswap,
                                               input logic flip);
        logic [15:0] t;
        t = bswap ? {h[7:0], h[15:8]} : h;
        order_bits = flip ? ~t : t;
    endfunction

    // pin synchroniser: {jumper, attention, req b, req a, data}
    logic [19:0] sync1_r, sync2_r;
    logic [1:0] prev_r;

    // only the second stage and prev_r are read by logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= `SYNC_RESET;
            sync2_r <= `SYNC_RESET;
            prev_r <= 2'b00;
        end else begin
            sync1_r <= {strobe_jumper_present, attention_input,
                        cycle_request_b, cycle_request_a, link_data_in};
            sync2_r <= sync1_r;
            prev_r <= {sync2_r[18], sync2_r[16]};
        end
    end

    logic [15:0] data_s;
    logic req_a_s, req_b_s, att_s, jumper_s;
    assign data_s = sync2_r[15:0];
    assign req_a_s = sync2_r[16];
    assign req_b_s = sync2_r[17];
    assign att_s = sync2_r[18];
    assign jumper_s = sync2_r[19];

    // registers and apb decode
    logic [15:0] cfg_r, cfg_nxt;
    logic [15:0] cmd_r, cmd_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic [15:0] status;
    link_pkg::reg_sel_type sel;
    logic wr;
    logic fn2_toggle;

    assign sel = reg_sel(paddr);
    assign wr = psel && penable && pwrite;
    assign fn2_toggle = wr && sel == link_pkg::sel_cmd
                        && pwdata[`CMD_FN2_BIT] != cmd_r[`CMD_FN2_BIT];

    // sequencer hookup
    logic seq_strobe, seq_sample, seq_ready, seq_eoc, seq_done;
    logic pol, blocked, req_edge, start;

    // request edge direction follows the polarity bit
    assign pol = cfg_r[`CFG_REQPOL_BIT];
    assign req_edge = (req_a_s == pol) && (prev_r[0] != pol);
    // request b counts as active at the level its edge moves to
    assign blocked = cfg_r[`CFG_ENB_BIT] && (req_b_s == pol);
    assign start = dma_active && req_edge && !blocked && !seq_strobe;

    // read data is latched in the setup phase, so answer has no wait
    always_comb begin
        status = 16'h0000;
        status[`STAT_READY_BIT] = seq_ready;
        status[`STAT_STROBE_BIT] = seq_strobe;
        status[`STAT_ATT_BIT] = att_s;
        status[`STAT_BLOCK_BIT] = blocked;
        status[`STAT_JUMPER_BIT] = jumper_s;
        status[`STAT_FN2_BIT] = function_line_two;
        cfg_nxt = cfg_r;
        cmd_nxt = cmd_r;
        prdata_nxt = prdata_r;
        if (wr && sel == link_pkg::sel_cfg) begin
            cfg_nxt = pwdata[15:0] & `CFG_MASK;
        end
        if (wr && sel == link_pkg::sel_cmd) begin
            cmd_nxt = pwdata[15:0] & `CMD_MASK;
        end
        if (psel && !penable) begin
            case (sel)
                link_pkg::sel_cmd: prdata_nxt = {16'h0000, cmd_r};
                link_pkg::sel_cfg: prdata_nxt = {16'h0000, cfg_r};
                link_pkg::sel_stat: prdata_nxt = {16'h0000, status};
                default: prdata_nxt = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r <= `CFG_RESET;
            cmd_r <= `CMD_RESET;
            prdata_r <= 32'h00000000;
        end else begin
            cfg_r <= cfg_nxt;
            cmd_r <= cmd_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = 1'b1;
    assign pslverr = psel && penable && sel == link_pkg::sel_none;

    // function line two: level or retriggered fixed-length pulse
    logic [7:0] pulse_cnt_r, pulse_cnt_nxt;
    logic fl2_r, fl2_nxt;

    always_comb begin
        if (fn2_toggle) begin
            pulse_cnt_nxt = 8'(`FN_PULSE_CYC);
        end else if (pulse_cnt_r != 8'h00) begin
            pulse_cnt_nxt = pulse_cnt_r - 8'h01;
        end else begin
            pulse_cnt_nxt = 8'h00;
        end
        if (cfg_r[`CFG_PULSE_BIT]) begin
            fl2_nxt = (pulse_cnt_nxt != 8'h00);
        end else begin
            fl2_nxt = cmd_nxt[`CMD_FN2_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_cnt_r <= 8'h00;
            fl2_r <= 1'b0;
        end else begin
            pulse_cnt_r <= pulse_cnt_nxt;
            fl2_r <= fl2_nxt;
        end
    end

    assign function_line_one = cmd_r[`CMD_FN1_BIT];
    assign function_line_two = fl2_r;
    assign function_line_three = cmd_r[`CMD_FN3_BIT];

    strobe_sequencer seq (
        .pclk(pclk),
        .presetn(presetn),
        .start(start),
        .last(dma_last),
        .ready_late(cfg_r[`CFG_RTIME_BIT]),
        .in_code(cfg_r[`CFG_IN_LSB +: 2]),
        .out_code(cfg_r[`CFG_OUT_LSB +: 2]),
        .strobe(seq_strobe),
        .sample(seq_sample),
        .ready(seq_ready),
        .eoc(seq_eoc),
        .done(seq_done)
    );

    // strobe pin: a missing jumper overrides the polarity bit
    logic strobe_low;
    assign strobe_low = !jumper_s || cfg_r[`CFG_SPOL_BIT];
    assign transfer_strobe_output = seq_strobe ^ strobe_low;
    assign device_ready = seq_ready;
    assign end_of_cycle = seq_eoc;
    assign dma_word_done = seq_done;

    // data path; data out is loaded at the edge the strobe starts
    logic [15:0] dout_r, dout_nxt;
    logic oe_r, oe_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic rvalid_r, rvalid_nxt;
    logic abort_r, abort_nxt;
    logic half, to_link;
    logic [15:0] in_word;

    assign half = dma_half_sel ^ cfg_r[`CFG_HSWAP_BIT];
    assign to_link = cmd_r[`CMD_DIR_BIT];

    always_comb begin
        dout_nxt = dout_r;
        oe_nxt = to_link;
        rdata_nxt = rdata_r;
        rvalid_nxt = 1'b0;
        in_word = order_bits(data_s, cfg_r[`CFG_BSWAP_BIT], cfg_r[`CFG_INVERT_BIT]);
        if (start && to_link) begin
            dout_nxt = order_bits(half ? dma_wdata[31:16] : dma_wdata[15:0],
                                  cfg_r[`CFG_BSWAP_BIT], cfg_r[`CFG_INVERT_BIT]);
        end
        if (seq_sample && !to_link) begin
            rdata_nxt = half ? {in_word, 16'h0000} : {16'h0000, in_word};
            rvalid_nxt = 1'b1;
        end
        // a rising attention aborts the dma unless told to keep it
        abort_nxt = att_s && !prev_r[1] && dma_active
                    && !cfg_r[`CFG_KEEP_BIT];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dout_r <= 16'h0000;
            oe_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rvalid_r <= 1'b0;
            abort_r <= 1'b0;
        end else begin
            dout_r <= dout_nxt;
            oe_r <= oe_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            abort_r <= abort_nxt;
        end
    end

    assign link_data_out = dout_r;
    assign link_data_oe = oe_r;
    assign dma_rdata = rdata_r;
    assign dma_rdata_valid = rvalid_r;
    assign dma_abort = abort_r;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    fn_pulse_len_a: assert property (
        cfg_r[`CFG_PULSE_BIT] && fn2_toggle
        |=> function_line_two ##59 (function_line_two || !cfg_r[`CFG_PULSE_BIT]))
        else $error("function line two pulse shorter than 60 cycles");

    fn_static_a: assert property (
        !$past(cfg_r[`CFG_PULSE_BIT]) |-> function_line_two == cmd_r[`CMD_FN2_BIT])
        else $error("function line two not following its command bit");

    fn_direct_a: assert property (
        wr && sel == link_pkg::sel_cmd
        |=> function_line_one == $past(pwdata[`CMD_FN1_BIT]))
        else $error("function line one not following its command bit");

    attention_keep_a: assert property (
        cfg_r[`CFG_KEEP_BIT] |=> !dma_abort)
        else $error("attention aborted dma while keep bit set");

    attention_abort_a: assert property (
        $rose(att_s) && dma_active && !cfg_r[`CFG_KEEP_BIT] |=> dma_abort)
        else $error("attention did not abort dma");

    half_swap_a: assert property (
        start && to_link && cfg_r[10:8] == 3'b100 && !dma_half_sel
        |=> link_data_out == $past(dma_wdata[31:16]))
        else $error("halfword order not swapped");

    data_inv_a: assert property (
        start && to_link && cfg_r[10:8] == 3'b010 && !dma_half_sel
        |=> link_data_out == ~$past(dma_wdata[15:0]))
        else $error("outgoing data not inverted");

    byte_swap_a: assert property (
        start && to_link && cfg_r[10:8] == 3'b001 && !dma_half_sel
        |=> link_data_out == {$past(dma_wdata[7:0]), $past(dma_wdata[15:8])})
        else $error("byte order not swapped");

    edge_fall_a: assert property (
        dma_active && !blocked && !seq_strobe && !pol && $fell(req_a_s) |=> seq_strobe)
        else $error("falling request edge did not start a transfer");

    req_b_block_a: assert property (
        blocked && !seq_strobe |=> !seq_strobe)
        else $error("transfer started while request b active");

    strobe_high_a: assert property (
        start && jumper_s && !cfg_r[`CFG_SPOL_BIT] |=> transfer_strobe_output)
        else $error("strobe not active high");

    strobe_forced_a: assert property (
        start && !jumper_s |=> !transfer_strobe_output)
        else $error("strobe not forced active low without jumper");

    strobe_low_a: assert property (
        start && jumper_s && cfg_r[`CFG_SPOL_BIT] |=> !transfer_strobe_output)
        else $error("strobe not active low with polarity bit set");

    last_late_c: cover property (start && dma_last && cfg_r[`CFG_RTIME_BIT]);
    inbound_c: cover property (dma_rdata_valid);
    abort_c: cover property (dma_abort);
    pulse_c: cover property ($fell(function_line_two) && cfg_r[`CFG_PULSE_BIT]);

endmodule

/* testbench/link_peer.sv */
// far-side peripheral model: request edges and the words it sends to the port
`timescale 1ns/10ps
module link_peer (
    // bench control
    input wire logic pclk,
    input wire logic go,
    input wire logic rise_start,
    input wire logic strobe_low,
    input wire logic [15:0] word_value,
    // link pins
    input wire logic transfer_strobe_output,
    output logic cycle_request_a,
    output logic [15:0] link_data_in
);
    // request rests away from the starting edge, so a pulled cable adds none
    always @(posedge pclk) begin
        cycle_request_a <= go ? rise_start : ~rise_start;
    end
    // word only under strobe; stale value inverted so it can never match
    always @(posedge pclk) begin
        link_data_in <= (transfer_strobe_output ^ strobe_low) ? word_value : ~word_value;
    end
endmodule

/* testbench/tb.sv */
// bench for the link configuration and word timing port
`timescale 1ns/10ps
module tb;
    localparam int LIMIT = 20000;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, dma_rdata, q;
    logic [31:0] dma_wdata = 32'h1234abcd;
    logic req_a, req_b, att_pin, jumper, strobe, rdy, eoc, fn1, fn2, fn3, oe, abort, valid;
    logic act, wdone;
    logic go, rise, slow, last, half;
    logic [15:0] din, dout, seen;
    logic [15:0] wval = 16'h5ac3;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    int nd = 0;
    parallel_link_config_timing dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cycle_request_a(req_a), .cycle_request_b(req_b),
        .attention_input(att_pin), .strobe_jumper_present(jumper), .link_data_in(din),
        .transfer_strobe_output(strobe), .device_ready(rdy), .end_of_cycle(eoc),
        .function_line_one(fn1), .function_line_two(fn2), .function_line_three(fn3),
        .link_data_out(dout), .link_data_oe(oe), .dma_active(act), .dma_last(last),
        .dma_half_sel(half), .dma_wdata(dma_wdata), .dma_word_done(wdone), .dma_rdata(dma_rdata),
        .dma_rdata_valid(valid), .dma_abort(abort));
    link_peer peer (.pclk(pclk), .go(go), .rise_start(rise), .strobe_low(slow),
        .word_value(wval), .transfer_strobe_output(strobe), .cycle_request_a(req_a),
        .link_data_in(din));
    initial begin
        pclk = 1'h0;
        forever #2.5 pclk = ~pclk;
    end
    // hang guard
    always @(posedge pclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            miscompares++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask
    // one apb transfer, held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        // a back-to-back call lets the release stand for one edge first
        if (psel === 1'h1) @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        q = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (n >= 50) check(32'h0, 32'h1, "apb hang");
    endtask
    // peer follows the written polarities one edge later
    task automatic set_cfg(input logic [15:0] c);
        apb(1'h1, 12'h318, {16'h0000, c});
        rise <= c[1];
        slow <= !jumper || c[0];
        @(posedge pclk);
    endtask
    function automatic logic [15:0] xform(input logic [15:0] h, input logic sw, input logic iv);
        logic [15:0] b;
        b = sw ? {h[7:0], h[15:8]} : h;
        return iv ? ~b : b;
    endfunction
    // one requested word, watched on the falling edge where outputs are settled
    task automatic run_word(input logic l, input logic hs, output int sl, output int rl,
                            output int en);
        sl = 0;
        rl = 0;
        en = 0;
        nd = 0;
        q = 'x;
        seen = 'x;
        last <= l;
        half <= hs;
        go <= 1'h1;
        repeat (90) begin
            @(negedge pclk);
            if ((strobe ^ slow) === 1'h1) begin
                sl++;
                seen = dout;
            end
            if (rdy === 1'h0) rl++;
            if (eoc === 1'h1) en++;
            if (wdone === 1'h1) nd++;
            if (valid === 1'h1) q = dma_rdata;
        end
        @(posedge pclk);
        go <= 1'h0;
        repeat (4) @(posedge pclk);
    endtask
    task automatic t_word(input logic [15:0] c, input logic dir, input logic l, input logic hs);
        int sl, rl, en, inn, len;
        logic [15:0] h;
        set_cfg(c);
        apb(1'h1, 12'h310, {28'h0, dir, 3'h0});
        run_word(l, hs, sl, rl, en);
        inn = (c[6:5] + 1) * 8;
        len = (inn + 1 > 2 + 8 * c[4:3]) ? inn + 1 : 2 + 8 * c[4:3];
        check(sl, len, "strobe length");
        check(rl, (l && !c[7]) ? inn : len, "ready low");
        check(en, l, "end of cycle");
        check(nd, 1, "word done");
        if (dir) begin
            h = xform((hs ^ c[10]) ? dma_wdata[31:16] : dma_wdata[15:0], c[8], c[9]);
            check(seen, h, "data out");
            check(oe, 1'h1, "data out enable");
        end else begin
            h = xform(wval, c[8], c[9]);
            check(q, (hs ^ c[10]) ? {h, 16'h0} : {16'h0, h}, "rx");
        end
        $display("done: word %h", c);
    endtask
    task automatic t_regs();
        apb(1'h0, 12'h318, 32'h0);
        check(q, 32'h0, "config reset");
        apb(1'h1, 12'h318, 32'hffffffff);
        apb(1'h0, 12'h318, 32'h0);
        check(q, 32'h00001fff, "config bits");
        apb(1'h0, 12'h3fc, 32'h0);
        check({31'h0, err}, 32'h1, "unmapped error");
        check(q, 32'h0, "unmapped read");
        set_cfg(16'h0000);
        $display("done: registers");
    endtask
    task automatic count_fn2(output int n);
        n = 0;
        repeat (80) begin
            @(negedge pclk);
            if (fn2 === 1'h1) n++;
        end
        @(posedge pclk);
    endtask
    task automatic t_funcs();
        int n;
        apb(1'h1, 12'h310, 32'h70);
        count_fn2(n);
        check({fn1, fn3}, 2'h3, "function lines");
        check(n, 80, "function two static");
        set_cfg(16'h1000);
        apb(1'h1, 12'h310, 32'h50);
        count_fn2(n);
        check(n, 60, "pulse on falling bit");
        apb(1'h1, 12'h310, 32'h70);
        count_fn2(n);
        check(n, 60, "pulse on rising bit");
        set_cfg(16'h0000);
        $display("done: function lines");
    endtask
    task automatic t_strobe();
        int sl, rl, en;
        @(negedge pclk);
        check(strobe, 1'h0, "idle active high");
        @(posedge pclk);
        set_cfg(16'h0001);
        @(negedge pclk);
        check(strobe, 1'h1, "idle active low");
        @(posedge pclk);
        jumper <= 1'h0;
        set_cfg(16'h0080);
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        check(strobe, 1'h1, "jumper forces low");
        @(posedge pclk);
        run_word(1'h1, 1'h0, sl, rl, en);
        check(sl, 9, "low strobe word");
        jumper <= 1'h1;
        set_cfg(16'h0084); // request b active at level 0
        run_word(1'h1, 1'h0, sl, rl, en);
        check(sl, 0, "blocked by request b");
        check(nd, 0, "no word done when blocked");
        req_b <= 1'h1;
        run_word(1'h1, 1'h0, sl, rl, en);
        check(sl, 9, "request b released");
        $display("done: strobe and blocking");
    endtask
    // an idle dma has nothing to abort
    task automatic t_attention(input logic keep, input logic on);
        int n;
        n = 0;
        set_cfg({4'h0, keep, 11'h080});
        act <= on;
        att_pin <= 1'h1;
        repeat (10) begin
            @(negedge pclk);
            if (abort === 1'h1) n++;
        end
        @(posedge pclk);
        att_pin <= 1'h0;
        act <= 1'h1;
        check(n, (keep || !on) ? 0 : 1, "abort on attention");
        $display("done: attention");
    endtask
    initial begin
        presetn = 1'h0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {req_b, att_pin, go, rise, slow, last, half} = '0;
        jumper = 1'h1;
        act = 1'h1;
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        repeat (3) @(posedge pclk);
        t_regs();
        t_funcs();
        t_strobe();
        set_cfg(16'h0000);
        t_word(16'h0080, 1'h0, 1'h1, 1'h0);
        t_word(16'h0060, 1'h0, 1'h1, 1'h1);
        t_word(16'h0718, 1'h1, 1'h0, 1'h0);
        t_word(16'h0400, 1'h1, 1'h1, 1'h0);
        t_word(16'h0200, 1'h1, 1'h0, 1'h0);
        t_word(16'h0100, 1'h1, 1'h1, 1'h0);
        t_word(16'h0582, 1'h0, 1'h1, 1'h1);
        t_word(16'h0221, 1'h0, 1'h0, 1'h0);
        t_attention(1'h0, 1'h1);
        t_attention(1'h1, 1'h1);
        t_attention(1'h0, 1'h0);
        print_verdict();
    end
endmodule
